// >>> rtl/tbsl_pkg.sv
package tbsl_pkg;
   // word and frame geometry
   localparam int WORD_W = 10;
   localparam int FRAME_W = 12;
   localparam int FRAME_HALF = 6;
   localparam int CNT_W = 4;
   // bit positions inside a 12-bit frame, bit 0 leaves the pin first
   localparam int START_POS = 0;
   localparam int STOP_POS = 11;
   // sync burst length in symbols and its counter width
   localparam int SYNC_MIN = 1024;
   localparam int SYNC_W = 11;
   // consecutive frames with bad clock bits that drop lock
   localparam int LOCK_LOSS = 4;
   localparam int BAD_W = 3;
   // sync symbol: five ones then five zeros between the clock bits
   localparam logic [9:0] SYNC_WORD = 10'h001F;
   localparam logic [11:0] SYNC_FRAME = {1'b0, SYNC_WORD, 1'b1};
   localparam logic [9:0] WORD_RST = 10'h0000;
   localparam logic [11:0] FRAME_RST = 12'h0000;

   // every pin that enters from outside the ref_clk domain
   typedef struct packed {
      logic alignA;
      logic alignB;
      logic txEdgeSel;
      logic txClk;
      logic driveEn;
      logic sleepN;
      logic rxEdgeSel;
      logic outEn;
      logic serP;
      logic serN;
      logic [WORD_W-1:0] dataIn;
   } tbsl_pins_s;

   // serializer state
   typedef struct packed {
      logic [FRAME_W-1:0] shift;
      logic [CNT_W-1:0] bitCnt;
      logic [SYNC_W-1:0] syncLeft;
      logic prevClk;
      logic pend;
      logic [WORD_W-1:0] pendWord;
      logic [WORD_W-1:0] lastWord;
      logic serP;
      logic serN;
      logic serOe;
   } tbsl_tx_s;

   // deserializer state
   typedef struct packed {
      logic [FRAME_W-1:0] win;
      logic lastBit;
      logic locked;
      logic [CNT_W-1:0] phase;
      logic [BAD_W-1:0] badCnt;
      logic [WORD_W-1:0] holdWord;
      logic [WORD_W-1:0] outWord;
      logic rclk;
      logic unsyncN;
      logic outOe;
   } tbsl_rx_s;
endpackage

// >>> rtl/tbsl_sync.sv
`timescale 1ns/1ns
// two-flop synchroniser bank for asynchronous pins
module tbsl_sync #(
   parameter int W = 1
) (
   // clock and reset
   input wire logic ref_clk,
   input wire logic rst,
   // raw and synchronised levels
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);
   typedef struct packed {
      logic [W-1:0] meta;
      logic [W-1:0] stable;
   } tbsl_sync_s;

   tbsl_sync_s s_q;
   tbsl_sync_s s_d;

   // meta stage feeds only the stable stage
   always_comb begin
      s_d.meta = d;
      s_d.stable = s_q.meta;
   end

   // register both stages, clear on reset
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   assign q = s_q.stable;
endmodule

// >>> rtl/tbsl_link.sv
`timescale 1ns/1ns
// Contract
// R1: capture 10-bit word on active transmit edge
// R2: edge select chooses rising or falling strobe
// R3: drive enable low tri-states serial legs
// R4: sleep stops everything, all outputs tri-stated
// R5: host clock stays within word rate limits; bench host strobes every 8 ref_clk cycles, frame is 12
// R6: sync request sends at least 1024 symbols
// R7: sync continues while request stays high
// R8: both align requests are ORed together
// R9: output word updates on selected recovered edge
// R10: unsynced flag low only while locked
// R11: recovered clock runs at word rate
// R12: output enable low tri-states receive outputs
// R13: system supplies the reference clock
// R14: sync frames lock and show sync word
// R15: controller waits for lock before disabling
// R16: two clock bits framed around each word
// R17: four bad frames in row drop lock
// R18: host may loop lock flag to request
// R19: frame is high bit, data LSB first, low
// R20: data passes unchanged end to end
module tbsl_link
   import tbsl_pkg::*;
(
   // clock and reset
   input wire logic ref_clk,
   input wire logic rst,
   // serializer host pins
   input wire logic [WORD_W-1:0] parallelInWord,
   input wire logic transmitClock,
   input wire logic txEdgeSelect,
   input wire logic alignRequestA,
   input wire logic alignRequestB,
   input wire logic serialDriveEnable,
   // shared sleep pin, low puts both halves to sleep
   input wire logic sleepN,
   // serial line out
   output logic serialOutP,
   output logic serialOutN,
   output logic serialOutOe,
   // serial line in
   input wire logic serialInP,
   input wire logic serialInN,
   // deserializer host pins
   input wire logic rxEdgeSelect,
   input wire logic parallelOutEnable,
   output logic [WORD_W-1:0] parallelOutWord,
   output logic recoveredClock,
   output logic linkUnsyncedN,
   output logic parallelOutOe
);
   tbsl_pins_s pinRaw; // pins as they arrive
   tbsl_pins_s pinS; // pins after two flops
   // whole state of the link in one word
   typedef struct packed {
      tbsl_tx_s tx;
      tbsl_rx_s rx;
   } tbsl_state_s;
   tbsl_state_s st_q; // registered state
   tbsl_state_s st_d; // next state
   tbsl_tx_s tx_q; // serializer view of st_q
   tbsl_tx_s tx_d; // serializer part of st_d
   tbsl_rx_s rx_q; // deserializer view of st_q
   tbsl_rx_s rx_d; // deserializer part of st_d
   logic txEdge; // chosen strobe edge seen this cycle
   logic syncReq; // merged align request
   logic frameEnd; // last bit of the current frame on the line
   logic rxBit; // decoded line bit
   logic frameDone; // a full frame sits in the receive window
   logic frameGood; // its clock bits are valid

   // frame builder, used for both data and idle repeats
   function automatic logic [FRAME_W-1:0] mkFrame(input logic [WORD_W-1:0] w);
      mkFrame = {1'b0, w, 1'b1};
   endfunction

   // pack raw pins for the synchroniser
   always_comb begin
      pinRaw.alignA = alignRequestA;
      pinRaw.alignB = alignRequestB;
      pinRaw.txEdgeSel = txEdgeSelect;
      pinRaw.txClk = transmitClock;
      pinRaw.driveEn = serialDriveEnable;
      pinRaw.sleepN = sleepN;
      pinRaw.rxEdgeSel = rxEdgeSelect;
      pinRaw.outEn = parallelOutEnable;
      pinRaw.serP = serialInP;
      pinRaw.serN = serialInN;
      pinRaw.dataIn = parallelInWord;
   end

   // every pin is asynchronous to ref_clk
   tbsl_sync #(
      .W($bits(tbsl_pins_s))
   ) tbsl_sync_i (
      .ref_clk(ref_clk),
      .rst(rst),
      .d(pinRaw),
      .q(pinS)
   );

   // next state of both halves, serializer first
   always_comb begin
      tx_d = tx_q;
      tx_d.prevClk = pinS.txClk;
      // R2: select strobe edge
      txEdge = pinS.txEdgeSel ? (pinS.txClk & ~tx_q.prevClk)
                              : (~pinS.txClk & tx_q.prevClk);
      // R8: requests are ORed
      syncReq = pinS.alignA | pinS.alignB;
      frameEnd = (tx_q.bitCnt == CNT_W'(STOP_POS));
      // R1: capture word on strobe
      if (txEdge) begin
         tx_d.pendWord = pinS.dataIn;
         tx_d.pend = 1'b1;
      end
      if (frameEnd) begin
         tx_d.bitCnt = '0;
         // R6: burst counter keeps sync going past a short request
         if (tx_q.syncLeft != '0 || syncReq) begin
            tx_d.shift = SYNC_FRAME;
            // R7: reload while request still held
            tx_d.syncLeft = (tx_q.syncLeft != '0) ? tx_q.syncLeft - 1'b1
                                                  : SYNC_W'(SYNC_MIN - 1);
         end else if (tx_d.pend) begin
            // R16: clock bits wrap the fresh word
            tx_d.shift = mkFrame(tx_d.pendWord);
            tx_d.lastWord = tx_d.pendWord;
            tx_d.pend = 1'b0;
         end else begin
            // no new word: repeat the last so the line keeps its clock
            tx_d.shift = mkFrame(tx_q.lastWord);
         end
      end else begin
         tx_d.bitCnt = tx_q.bitCnt + 1'b1;
         // R19: low bit first out
         tx_d.shift = {1'b0, tx_q.shift[FRAME_W-1:1]};
      end
      tx_d.serP = tx_d.shift[START_POS];
      tx_d.serN = ~tx_d.shift[START_POS];
      // R3: drive enable gates the legs
      tx_d.serOe = pinS.driveEn;
      // R4: sleep resets the serializer and floats its outputs
      if (!pinS.sleepN) begin
         tx_d = '0;
         tx_d.bitCnt = CNT_W'(STOP_POS);
      end
      // deserializer next state
      rx_d = rx_q;
      // legs that agree carry no valid level, so hold the last bit
      rxBit = (pinS.serP != pinS.serN) ? pinS.serP : rx_q.lastBit;
      rx_d.lastBit = rxBit;
      rx_d.win = {rxBit, rx_q.win[FRAME_W-1:1]};
      frameGood = rx_d.win[START_POS] & ~rx_d.win[STOP_POS];
      frameDone = rx_q.locked && (rx_q.phase == CNT_W'(STOP_POS));
      if (!rx_q.locked) begin
         // R14: a sync frame filling the whole window gives alignment
         if (rx_d.win == SYNC_FRAME) begin
            rx_d.locked = 1'b1;
            rx_d.phase = '0;
            rx_d.badCnt = '0;
            rx_d.holdWord = rx_d.win[WORD_W:1];
         end
      end else if (frameDone) begin
         rx_d.phase = '0;
         if (frameGood) begin
            // R20: good frame carries the word unchanged
            rx_d.holdWord = rx_d.win[WORD_W:1];
            rx_d.badCnt = '0;
         end else if (rx_q.badCnt == BAD_W'(LOCK_LOSS - 1)) begin
            // R17: lock lost on the fourth bad frame
            rx_d.locked = 1'b0;
            rx_d.badCnt = '0;
         end else begin
            rx_d.badCnt = rx_q.badCnt + 1'b1;
         end
      end else begin
         rx_d.phase = rx_q.phase + 1'b1;
      end
      // R11: clock high for the first half of each word
      rx_d.rclk = rx_d.locked && (rx_d.phase < CNT_W'(FRAME_HALF));
      // R9: word moves on the chosen recovered edge
      if (rx_d.rclk && !rx_q.rclk && pinS.rxEdgeSel) begin
         rx_d.outWord = rx_d.holdWord;
      end else if (!rx_d.rclk && rx_q.rclk && !pinS.rxEdgeSel) begin
         rx_d.outWord = rx_d.holdWord;
      end
      // R10: flag low only while locked
      rx_d.unsyncN = ~rx_d.locked;
      // R12: output enable gates word, flag and clock
      rx_d.outOe = pinS.outEn;
      // R4: sleep drops lock and floats everything
      if (!pinS.sleepN) begin
         rx_d = '0;
         rx_d.unsyncN = 1'b1;
      end
      st_d.tx = tx_d;
      st_d.rx = rx_d;
   end

   // one register for all state; reset parks the serializer at a frame end
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         st_q <= '0;
         st_q.tx.bitCnt <= CNT_W'(STOP_POS);
         st_q.rx.unsyncN <= 1'b1;
      end else begin
         st_q <= st_d;
      end
   end

   // named views of the two halves
   assign tx_q = st_q.tx;
   assign rx_q = st_q.rx;

   // outputs straight from state flops
   assign serialOutP = tx_q.serP;
   assign serialOutN = tx_q.serN;
   assign serialOutOe = tx_q.serOe;
   assign parallelOutWord = rx_q.outWord;
   assign recoveredClock = rx_q.rclk;
   assign linkUnsyncedN = rx_q.unsyncN;
   assign parallelOutOe = rx_q.outOe;

   a_sleep_hiz_all: assert property ( // R4
      @(posedge ref_clk) disable iff (rst)
      !pinS.sleepN |=> !serialOutOe && !parallelOutOe && linkUnsyncedN)
      else $error("outputs driven while asleep");

   a_drive_en_hiz: assert property ( // R3
      @(posedge ref_clk) disable iff (rst)
      (pinS.sleepN && !pinS.driveEn) |=> !serialOutOe)
      else $error("serial legs driven while disabled");

   a_rx_out_hiz: assert property ( // R12
      @(posedge ref_clk) disable iff (rst)
      !pinS.outEn |=> !parallelOutOe)
      else $error("receive outputs driven while disabled");

   a_word_capture: assert property ( // R1
      @(posedge ref_clk) disable iff (rst)
      (pinS.sleepN && txEdge)
      |=> (tx_q.pend && tx_q.pendWord == $past(pinS.dataIn))
          || (!tx_q.pend && tx_q.lastWord == $past(pinS.dataIn)))
      else $error("strobed word not captured");

   a_sync_or_req: assert property ( // R8
      @(posedge ref_clk) disable iff (rst)
      (pinS.sleepN && frameEnd && (pinS.alignA || pinS.alignB))
      |=> tx_q.shift == SYNC_FRAME && serialOutP)
      else $error("either request must start a sync symbol");

   a_sync_burst_min: assert property ( // R6
      @(posedge ref_clk) disable iff (rst)
      (pinS.sleepN && frameEnd && tx_q.syncLeft == '0 && syncReq)
      |=> tx_q.syncLeft == SYNC_W'(SYNC_MIN - 1))
      else $error("sync burst not loaded to full length");

   a_frame_clock_bits: assert property ( // R16
      @(posedge ref_clk) disable iff (rst)
      (pinS.sleepN && tx_q.bitCnt == '0)
      |-> tx_q.shift[START_POS] && !tx_q.shift[STOP_POS])
      else $error("frame clock bits wrong");

   a_lock_loss_four: assert property ( // R17
      @(posedge ref_clk) disable iff (rst)
      ($fell(rx_q.locked) && $past(pinS.sleepN))
      |-> $past(rx_q.badCnt) == BAD_W'(LOCK_LOSS - 1))
      else $error("lock dropped before four bad frames");

   a_rclk_half_word: assert property ( // R11
      @(posedge ref_clk) disable iff (rst || !pinS.sleepN)
      $rose(recoveredClock) |-> recoveredClock [*6] ##1 !recoveredClock)
      else $error("recovered clock high time wrong");
endmodule

// >>> testbench/tbsl_host.sv
`timescale 1ns/1ns
// host side: slow word clock, word source, serial loop
module tbsl_host
   import tbsl_pkg::*;
(
   // clock and reset
   input wire logic ref_clk,
   input wire logic rst,
   // word source
   input wire logic run,
   input wire logic [WORD_W-1:0] riseWord,
   input wire logic [WORD_W-1:0] fallWord,
   output logic transmitClock,
   output logic [WORD_W-1:0] parallelInWord,
   // serial loop
   input wire logic serialOutP,
   input wire logic serialOutN,
   input wire logic serialOutOe,
   output logic serialInP,
   output logic serialInN
);
   logic [2:0] cnt; // phase in one 8-cycle host clock
   logic lastP; // last driven level on the line
   // slow clock, word stable around its edge
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         cnt <= 3'h0;
         parallelInWord <= 10'h0000;
      end else if (run) begin
         cnt <= cnt + 3'h1;
         // rise word held cycles 2..5, fall word 6..1
         if (cnt == 3'h1) parallelInWord <= riseWord;
         if (cnt == 3'h5) parallelInWord <= fallWord;
      end
   end
   assign transmitClock = cnt[2];
   // released line shows the inverse, so stale bits never pass as valid
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         lastP <= 1'b0;
      end else if (serialOutOe) begin
         lastP <= serialOutP;
      end
   end
   assign serialInP = serialOutOe ? serialOutP : ~lastP;
   assign serialInN = serialOutOe ? serialOutN : lastP;
endmodule

// >>> testbench/tbsl_link_bench.sv
`timescale 1ns/1ns
`define CHK(nm, ex, got) begin cmp_count++; if ((got) !== (ex)) begin errors++; $display("BAD %s exp %h got %h", nm, ex, got); end end
module tbsl_link_bench;
   import tbsl_pkg::*;
   // pins driven by the bench
   logic ref_clk = 1'b0;
   logic rst = 1'b1;
   logic txEdgeSelect = 1'b1;
   logic alignRequestA = 1'b0;
   logic alignRequestB = 1'b0;
   logic serialDriveEnable = 1'b1;
   logic sleepN = 1'b1;
   logic rxEdgeSelect = 1'b0;
   logic parallelOutEnable = 1'b1;
   logic run = 1'b0;
   logic [WORD_W-1:0] riseWord = 10'h02A5;
   logic [WORD_W-1:0] fallWord = 10'h00CA;
   // observed wires
   logic [WORD_W-1:0] parallelInWord, parallelOutWord;
   logic transmitClock, serialOutP, serialOutN, serialOutOe, serialInP, serialInN;
   logic recoveredClock, linkUnsyncedN, parallelOutOe;
   int errors = 0;
   int cmp_count = 0;
   int n;
   tbsl_link tbsl_link_i (.ref_clk, .rst, .parallelInWord, .transmitClock, .txEdgeSelect,
      .alignRequestA, .alignRequestB, .serialDriveEnable, .sleepN, .serialOutP, .serialOutN,
      .serialOutOe, .serialInP, .serialInN, .rxEdgeSelect, .parallelOutEnable,
      .parallelOutWord, .recoveredClock, .linkUnsyncedN, .parallelOutOe);
   tbsl_host tbsl_host_i (.ref_clk, .rst, .run, .riseWord, .fallWord, .transmitClock,
      .parallelInWord, .serialOutP, .serialOutN, .serialOutOe, .serialInP, .serialInN);
   initial begin
      forever #5 ref_clk = ~ref_clk;
   end
   // one cycle, sampled mid-period; word may only move on the chosen edge
   task automatic step();
      logic [WORD_W-1:0] w;
      logic c;
      w = parallelOutWord;
      c = recoveredClock;
      @(negedge ref_clk);
      if (parallelOutWord !== w && linkUnsyncedN === 1'b0)
         `CHK("strobe edge", {rxEdgeSelect, ~rxEdgeSelect}, {recoveredClock, c})
   endtask
   task automatic t_sync();
      @(posedge ref_clk);
      `CHK("unsynced before sync", 1'b1, linkUnsyncedN)
      run <= 1'b1;
      alignRequestA <= 1'b1;
      n = 0;
      while (linkUnsyncedN !== 1'b0 && n < 200) begin step(); n++; end
      `CHK("lock", 1'b0, linkUnsyncedN)
      @(posedge ref_clk);
      alignRequestA <= 1'b0;
      repeat (FRAME_W) step();
      `CHK("sync word", SYNC_WORD, parallelOutWord)
      n = 0;
      while (parallelOutWord === SYNC_WORD && n < 20000) begin step(); n++; end
      `CHK("burst min", 1'b1, n >= (SYNC_MIN - 2) * FRAME_W)
      `CHK("burst max", 1'b1, n <= (SYNC_MIN + 2) * FRAME_W)
      `CHK("data word", riseWord, parallelOutWord)
   endtask
   task automatic t_edge();
      @(posedge ref_clk);
      txEdgeSelect <= 1'b0;
      repeat (60) step();
      `CHK("fall capture", fallWord, parallelOutWord)
      @(posedge ref_clk);
      txEdgeSelect <= 1'b1;
      riseWord <= 10'h0155;
      repeat (60) step();
      `CHK("rise capture", 10'h0155, parallelOutWord)
      `CHK("inverted leg", ~serialOutP, serialOutN)
   endtask
   task automatic t_off();
      @(posedge ref_clk);
      parallelOutEnable <= 1'b0;
      repeat (6) step();
      `CHK("rx outputs off", 1'b0, parallelOutOe)
      @(posedge ref_clk);
      parallelOutEnable <= 1'b1;
      serialDriveEnable <= 1'b0;
      n = 0;
      while (linkUnsyncedN !== 1'b1 && n < 100) begin step(); n++; end
      `CHK("legs off", 1'b0, serialOutOe)
      `CHK("lock lost", 1'b1, linkUnsyncedN)
      `CHK("lock kept 3 frames", 1'b1, n > 3 * FRAME_W)
      @(posedge ref_clk);
      rxEdgeSelect <= 1'b1;
      serialDriveEnable <= 1'b1;
      sleepN <= 1'b0;
      repeat (8) step();
      `CHK("sleep all off", 2'b00, {serialOutOe, parallelOutOe})
      @(posedge ref_clk);
      sleepN <= 1'b1;
      repeat (8) step();
      `CHK("awake legs on", 1'b1, serialOutOe)
   endtask
   task automatic t_hold();
      @(posedge ref_clk);
      alignRequestB <= 1'b1;
      n = 0;
      while (linkUnsyncedN !== 1'b0 && n < 200) begin step(); n++; end
      `CHK("relock", 1'b0, linkUnsyncedN)
      repeat ((SYNC_MIN + 50) * FRAME_W) step();
      `CHK("sync held", SYNC_WORD, parallelOutWord)
      @(posedge ref_clk);
      alignRequestB <= 1'b0;
      n = 0;
      while (parallelOutWord === SYNC_WORD && n < 26000) begin step(); n++; end
      `CHK("data after hold", 10'h0155, parallelOutWord)
   endtask
   // single end of run
   task automatic close_out();
      $display("checks %0d mismatches %0d", cmp_count, errors);
      if (errors == 0 && cmp_count > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask
   initial begin
      repeat (15) @(posedge ref_clk);
      @(negedge ref_clk);
      `CHK("oe in reset", 2'b00, {serialOutOe, parallelOutOe})
      `CHK("unsynced in reset", 1'b1, linkUnsyncedN)
      @(posedge ref_clk);
      rst <= 1'b0;
      t_sync();
      $display("sync test done");
      t_edge();
      $display("edge test done");
      t_off();
      $display("disable test done");
      t_hold();
      $display("hold test done");
      close_out();
   end
   // hang guard, well above the longest expected run
   initial begin
      repeat (70000) @(posedge ref_clk);
      errors++;
      close_out();
   end
endmodule
